// ### backplane_pkg.sv
package backplane_pkg;
	// ==========================================================
	// Sizes
	localparam int N_SLOTS = 14;
	localparam int SLOT_W  = 4;
	localparam int DMA_W   = 8;
	localparam int WAIT_W  = 4;

	// ==========================================================
	// Timing
	localparam int REF_PERIOD_NS     = 5;
	localparam int BP_HALF_CYC       = 4;
	localparam int CMD_BP_CYC        = 2;
	localparam int READY_MAX_TIME_US = 10;
	localparam int READY_MAX_CYC     = (READY_MAX_TIME_US * 1000) / REF_PERIOD_NS;
	localparam int READY_CNT_W       = 12;

	// ==========================================================
	// Values after reset
	localparam logic [DMA_W-1:0]  DMA_CNT_RST  = 8'h00;
	localparam logic [WAIT_W-1:0] WAIT_CNT_RST = 4'h0;

	// ==========================================================
	// States
	typedef enum logic [2:0] {
		CY_IDLE  = 3'h0,
		CY_SETUP = 3'h1,
		CY_START = 3'h2,
		CY_CMD   = 3'h3,
		CY_BWAIT = 3'h4
	} cycle_state_type;

	typedef enum logic [1:0] {
		DM_IDLE = 2'h0,
		DM_XFER = 2'h1,
		DM_GAP  = 2'h2
	} dma_state_type;

	typedef enum logic [2:0] {
		FM_IDLE  = 3'h0,
		FM_CLAIM = 3'h1,
		FM_ADDR  = 3'h2,
		FM_START = 3'h3,
		FM_WAIT  = 3'h4,
		FM_DONE  = 3'h5
	} far_master_state_type;
endpackage

// ### backplane_if.sv
`timescale 1ns/100ps
interface backplane_if #(parameter int N = backplane_pkg::N_SLOTS);
	logic         bp_clk;
	logic         command_n;
	logic [N-1:0] grant_acknowledge_n;
	logic [N-1:0] dma_grant_acknowledge_n;
	logic [N-1:0] master_claim_n;
	logic [N-1:0] dma_slot_request_n;
	logic [N-1:0] slot_interrupt_line;
	logic         shared_bus_request_n;
	logic dev_start_o, dev_start_oe, far_start_o, far_start_oe;
	logic dev_mio_o, dev_mio_oe, far_mio_o, far_mio_oe;
	logic dev_lock_oe, far_lock_oe, far_nowait_oe, far_ready_oe;
	logic dev_m2io_o, dev_m2io_oe, dev_io2m_o, dev_io2m_oe;
	logic dev_tc_o, dev_tc_oe, far_tc_o, far_tc_oe;
	logic cycle_start_n, mem_io_sel, lock_n, no_wait_request_n, slave_ready_signal;
	logic dma_mem_to_io_strobe_n, dma_io_to_mem_strobe_n, count_end;

	// ==========================================================
	// Wire levels with pull-ups
	assign cycle_start_n = ~((dev_start_oe & ~dev_start_o) | (far_start_oe & ~far_start_o));
	assign mem_io_sel = far_mio_oe ? far_mio_o : (dev_mio_oe ? dev_mio_o : 1'b1);
	assign lock_n = ~(dev_lock_oe | far_lock_oe);
	assign no_wait_request_n = ~far_nowait_oe;
	assign slave_ready_signal = ~far_ready_oe;
	assign dma_mem_to_io_strobe_n = ~(dev_m2io_oe & ~dev_m2io_o);
	assign dma_io_to_mem_strobe_n = ~(dev_io2m_oe & ~dev_io2m_o);
	assign count_end = (dev_tc_oe & dev_tc_o) | (far_tc_oe & far_tc_o);

	modport central (
		output bp_clk, command_n, grant_acknowledge_n, dma_grant_acknowledge_n,
		output dev_start_o, dev_start_oe, dev_mio_o, dev_mio_oe, dev_lock_oe,
		output dev_m2io_o, dev_m2io_oe, dev_io2m_o, dev_io2m_oe, dev_tc_o, dev_tc_oe,
		input  master_claim_n, dma_slot_request_n, slot_interrupt_line, shared_bus_request_n,
		input  cycle_start_n, mem_io_sel, lock_n, no_wait_request_n, slave_ready_signal,
		input  count_end, dma_mem_to_io_strobe_n, dma_io_to_mem_strobe_n
	);
	modport board (
		output master_claim_n, dma_slot_request_n, slot_interrupt_line, shared_bus_request_n,
		output far_start_o, far_start_oe, far_mio_o, far_mio_oe, far_lock_oe,
		output far_nowait_oe, far_ready_oe, far_tc_o, far_tc_oe,
		input  bp_clk, command_n, grant_acknowledge_n, dma_grant_acknowledge_n,
		input  cycle_start_n, mem_io_sel, lock_n, no_wait_request_n, slave_ready_signal,
		input  count_end, dma_mem_to_io_strobe_n, dma_io_to_mem_strobe_n
	);
endinterface

// ### edge_sync.sv
`timescale 1ns/100ps
module edge_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	input  wire logic [W-1:0] rst_val,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	// ==========================================================
	// Two-stage synchroniser, edges taken after the second stage
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			meta_q <= rst_val;
			sync_q <= rst_val;
			prev_q <= rst_val;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise  = sync_q & ~prev_q;
	assign fall  = ~sync_q & prev_q;
endmodule

// ### central_end.sv
`timescale 1ns/100ps
// Behaviour
// - Command asserts as cycle-start negates
// - Command negates on clock; always driven
// - Start only after address/select valid
// - Release start for claims, not shared
// - No-wait request ends transfer early
// - Grant highest-priority active master claim
// - Grant changes only on rising edge
// - Claims change only on falling edge
// - Borrowing master drives managed signal set
// - Synchronise interrupts, edge or level mode
// - Ready low extends the cycle
// - Slaves change ready on clock only; board_end's ready timeout releases it on any ref_clk edge
// - No DMA/interrupt service while not ready
// - Ready low no longer than 10us
// - Lock gives exclusivity; masters monitor lock
// - Memory-to-I/O strobe qualified by DMA grant
// - I/O-to-memory strobe qualified by DMA grant
// - Slave count-end only under DMA grant
// - Count-end driven on count roll-over
// - DMA request gets grant and operation
// - Per-slot lines for fourteen slots
// - Select high memory, low I/O
module central_end #(
	parameter int N        = backplane_pkg::N_SLOTS,
	parameter int CMD_CYC  = backplane_pkg::CMD_BP_CYC,
	parameter int HALF_CYC = backplane_pkg::BP_HALF_CYC
) (
	input  wire logic                             ref_clk,
	input  wire logic                             rst_n,
	backplane_if.central                          bp,
	input  wire logic                             req_valid,
	input  wire logic                             req_mem,
	input  wire logic                             req_lock,
	output logic                                  req_ready,
	output logic                                  req_done,
	output logic                                  req_early,
	input  wire logic [N-1:0]                     irq_edge_mode,
	output logic      [N-1:0]                     irq_pending,
	input  wire logic                             dma_mem_to_io,
	input  wire logic [backplane_pkg::DMA_W-1:0]  dma_len,
	output logic                                  dma_active,
	output logic                                  dma_beat,
	output logic      [backplane_pkg::SLOT_W-1:0] dma_slot,
	output logic                                  borrowed,
	output logic      [backplane_pkg::SLOT_W-1:0] owner_slot,
	output logic                                  shared_granted
);
	localparam int SW = backplane_pkg::SLOT_W;
	localparam int DW = backplane_pkg::DMA_W;
	localparam int SV = 3 * N + 6;

	// ==========================================================
	// Lowest index wins; returns {found, index}
	function automatic logic [SW:0] first_low(input logic [N-1:0] v);
		logic [SW:0] r;
		r = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (!v[i]) begin
				r = {1'b1, SW'(i)};
			end
		end
		return r;
	endfunction

	// ==========================================================
	// Backplane clock divider
	logic [3:0] div_q;
	logic       bpclk_q;
	logic       tick;
	assign tick = (div_q == 4'(HALF_CYC - 1)) && !bpclk_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			div_q   <= 4'h0;
			bpclk_q <= 1'b0;
		end else if (div_q == 4'(HALF_CYC - 1)) begin
			div_q   <= 4'h0;
			bpclk_q <= ~bpclk_q;
		end else begin
			div_q <= div_q + 4'h1;
		end
	end
	assign bp.bp_clk = bpclk_q;

	// ==========================================================
	// Synchronisers for every line the boards drive except mem_io_sel
	logic [SV-1:0] s_lvl;
	logic [SV-1:0] s_rise;
	logic [N-1:0]  claim_s;
	logic [N-1:0]  dreq_s;
	logic [N-1:0]  irq_s;
	logic [N-1:0]  irq_r;
	logic          start_s;
	logic          nowait_s;
	logic          ready_s;
	logic          lock_s;
	logic          tc_s;
	logic          shared_bus_request_s;

	edge_sync #(.W(SV)) u_sync (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.async_in ({bp.master_claim_n, bp.dma_slot_request_n, bp.slot_interrupt_line,
			bp.cycle_start_n, bp.no_wait_request_n, bp.slave_ready_signal,
			bp.lock_n, bp.count_end, bp.shared_bus_request_n}),
		.rst_val  ({{(2 * N){1'b1}}, {N{1'b0}}, 6'h3D}),
		.level    (s_lvl),
		.rise     (s_rise),
		.fall     ()
	);
	assign {claim_s, dreq_s, irq_s, start_s, nowait_s, ready_s, lock_s, tc_s, shared_bus_request_s} = s_lvl;
	assign irq_r = s_rise[N + 5:6];

	// ==========================================================
	// Cycle sequencer
	backplane_pkg::cycle_state_type cyc_q;
	logic [3:0] cmd_cnt_q;
	logic       own_q;
	logic       command_n_q;
	logic       start_o_q;
	logic       mio_q;
	logic       mio_oe_q;
	logic       lock_oe_q;
	logic       grant_v_q;
	logic [SW-1:0] grant_i_q;
	backplane_pkg::dma_state_type dma_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cyc_q       <= backplane_pkg::CY_IDLE;
			cmd_cnt_q   <= 4'h0;
			own_q       <= 1'b0;
			command_n_q <= 1'b1;
			start_o_q   <= 1'b1;
			mio_q       <= 1'b1;
			mio_oe_q    <= 1'b0;
			lock_oe_q   <= 1'b0;
			req_done    <= 1'b0;
			req_early   <= 1'b0;
		end else begin
			req_done  <= 1'b0;
			req_early <= 1'b0;
			unique case (cyc_q)
				backplane_pkg::CY_IDLE: begin
					if (req_valid && req_ready) begin
						mio_q     <= req_mem;
						mio_oe_q  <= 1'b1;
						lock_oe_q <= req_lock;
						own_q     <= 1'b1;
						cyc_q     <= backplane_pkg::CY_SETUP;
					end else if (tick && grant_v_q && !start_s) begin
						own_q <= 1'b0;
						cyc_q <= backplane_pkg::CY_BWAIT;
					end
				end
				backplane_pkg::CY_SETUP: begin
					if (tick) begin
						start_o_q <= 1'b0;
						cyc_q     <= backplane_pkg::CY_START;
					end
				end
				backplane_pkg::CY_START, backplane_pkg::CY_BWAIT: begin
					if (tick && (own_q || start_s)) begin
						start_o_q   <= 1'b1;
						command_n_q <= 1'b0;
						cmd_cnt_q   <= 4'(CMD_CYC);
						cyc_q       <= backplane_pkg::CY_CMD;
					end
				end
				backplane_pkg::CY_CMD: begin
					if (tick) begin
						if (cmd_cnt_q > 4'h1) begin
							cmd_cnt_q <= cmd_cnt_q - 4'h1;
						end
						if (ready_s && (!nowait_s || cmd_cnt_q <= 4'h1)) begin
							command_n_q <= 1'b1;
							mio_oe_q    <= 1'b0;
							lock_oe_q   <= 1'b0;
							req_done    <= own_q;
							req_early   <= own_q && !nowait_s && cmd_cnt_q > 4'h1;
							cyc_q       <= backplane_pkg::CY_IDLE;
						end
					end
				end
				default: cyc_q <= backplane_pkg::CY_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			req_ready <= 1'b0;
		end else begin
			req_ready <= cyc_q == backplane_pkg::CY_IDLE && !grant_v_q
				&& dma_q == backplane_pkg::DM_IDLE && !(req_valid && req_ready) && !tick;
		end
	end

	assign bp.command_n    = command_n_q;
	assign bp.dev_start_o  = start_o_q;
	assign bp.dev_start_oe = !grant_v_q;
	assign bp.dev_mio_o    = mio_q;
	assign bp.dev_mio_oe   = mio_oe_q;
	assign bp.dev_lock_oe  = lock_oe_q;

	// ==========================================================
	// Master claim arbiter
	logic [SW:0]   pick;
	logic [N-1:0]  gack_n_q;
	logic          arb_free;
	assign pick     = first_low(claim_s);
	assign arb_free = cyc_q == backplane_pkg::CY_IDLE && !(req_valid && req_ready)
		&& dma_q == backplane_pkg::DM_IDLE && lock_s;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			grant_v_q      <= 1'b0;
			grant_i_q      <= '0;
			gack_n_q       <= '1;
			shared_granted <= 1'b0;
		end else if (tick) begin
			shared_granted <= !shared_bus_request_s && !grant_v_q && arb_free;
			if (grant_v_q) begin
				if (claim_s[grant_i_q] && cyc_q == backplane_pkg::CY_IDLE) begin
					grant_v_q <= 1'b0;
					gack_n_q  <= '1;
				end
			end else if (pick[SW] && arb_free && shared_bus_request_s) begin
				grant_v_q           <= 1'b1;
				grant_i_q           <= pick[SW-1:0];
				gack_n_q            <= '1;
				gack_n_q[pick[SW-1:0]] <= 1'b0;
			end
		end
	end

	assign bp.grant_acknowledge_n = gack_n_q;
	assign borrowed   = grant_v_q;
	assign owner_slot = grant_i_q;

	// ==========================================================
	// DMA channel
	logic [SW:0]    dpick;
	logic [DW-1:0]  dcnt_q;
	logic [N-1:0]   dak_n_q;
	logic           strobe_q;
	logic           dir_q;
	logic           tc_q;
	assign dpick = first_low(dreq_s);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dma_q      <= backplane_pkg::DM_IDLE;
			dcnt_q     <= backplane_pkg::DMA_CNT_RST;
			dak_n_q    <= '1;
			strobe_q   <= 1'b0;
			dir_q      <= 1'b0;
			tc_q       <= 1'b0;
			dma_slot   <= '0;
			dma_active <= 1'b0;
			dma_beat   <= 1'b0;
		end else begin
			dma_beat <= 1'b0;
			if (tick) begin
				unique case (dma_q)
					backplane_pkg::DM_IDLE: begin
						if (dpick[SW] && ready_s && !grant_v_q && shared_bus_request_s
							&& cyc_q == backplane_pkg::CY_IDLE && !(req_valid && req_ready)) begin
							dak_n_q               <= '1;
							dak_n_q[dpick[SW-1:0]] <= 1'b0;
							dma_slot              <= dpick[SW-1:0];
							dcnt_q                <= dma_len;
							dir_q                 <= dma_mem_to_io;
							dma_active            <= 1'b1;
							dma_q                 <= backplane_pkg::DM_GAP;
						end
					end
					backplane_pkg::DM_GAP: begin
						if (dreq_s[dma_slot] || (tc_s && !tc_q)) begin
							dak_n_q    <= '1;
							dma_active <= 1'b0;
							dma_q      <= backplane_pkg::DM_IDLE;
						end else if (ready_s) begin
							strobe_q <= 1'b1;
							tc_q     <= dcnt_q == 8'h01;
							dma_q    <= backplane_pkg::DM_XFER;
						end
					end
					backplane_pkg::DM_XFER: begin
						if (ready_s) begin
							strobe_q <= 1'b0;
							dma_beat <= 1'b1;
							dcnt_q   <= dcnt_q - 8'h01;
							tc_q     <= 1'b0;
							if (tc_q || tc_s) begin
								dak_n_q    <= '1;
								dma_active <= 1'b0;
								dma_q      <= backplane_pkg::DM_IDLE;
							end else begin
								dma_q <= backplane_pkg::DM_GAP;
							end
						end
					end
					default: dma_q <= backplane_pkg::DM_IDLE;
				endcase
			end
		end
	end

	assign bp.dma_grant_acknowledge_n = dak_n_q;
	assign bp.dev_m2io_o  = ~(strobe_q && dir_q);
	assign bp.dev_m2io_oe = !grant_v_q;
	assign bp.dev_io2m_o  = ~(strobe_q && !dir_q);
	assign bp.dev_io2m_oe = !grant_v_q;
	assign bp.dev_tc_o    = tc_q;
	assign bp.dev_tc_oe   = tc_q;

	// ==========================================================
	// Interrupt capture, suspended while the slave holds ready low
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq_pending <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				irq_pending[i] <= ready_s && (irq_edge_mode[i] ? irq_r[i] : !irq_s[i]);
			end
		end
	end
endmodule

// ### board_end.sv
`timescale 1ns/100ps
module board_end #(
	parameter int N         = backplane_pkg::N_SLOTS,
	parameter int SLOT      = 1,
	parameter int READY_MAX = backplane_pkg::READY_MAX_CYC
) (
	input  wire logic                             ref_clk,
	input  wire logic                             rst_n,
	backplane_if.board                            bp,
	input  wire logic [backplane_pkg::WAIT_W-1:0] slave_wait,
	input  wire logic                             slave_fast,
	output logic                                  slave_access,
	output logic                                  slave_mem,
	input  wire logic                             irq_in,
	input  wire logic                             shared_req,
	input  wire logic                             dma_req,
	input  wire logic                             dma_stop,
	output logic                                  dma_xfer,
	output logic                                  dma_to_io,
	output logic                                  dma_done,
	input  wire logic                             bm_req,
	input  wire logic                             bm_mem,
	input  wire logic                             bm_lock,
	output logic                                  bm_busy,
	output logic                                  bm_done
);
	localparam int WW = backplane_pkg::WAIT_W;
	localparam int RW = backplane_pkg::READY_CNT_W;

	// ==========================================================
	// Synchronised backplane view
	logic [7:0] lvl;
	logic [7:0] rs;
	logic [7:0] fl;
	logic       bp_rise;
	logic       bp_fall;
	logic       cmd_s;
	logic       start_s;
	logic       gack_s;
	logic       dak_s;
	logic       tc_s;

	edge_sync #(.W(8)) u_sync (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.async_in ({bp.bp_clk, bp.command_n, bp.cycle_start_n, bp.dma_mem_to_io_strobe_n,
			bp.dma_io_to_mem_strobe_n, bp.count_end, bp.grant_acknowledge_n[SLOT],
			bp.dma_grant_acknowledge_n[SLOT]}),
		.rst_val  (8'h7B),
		.level    (lvl),
		.rise     (rs),
		.fall     (fl)
	);
	assign bp_rise = rs[7];
	assign bp_fall = fl[7];
	assign cmd_s   = lvl[6];
	assign start_s = lvl[5];
	assign tc_s    = lvl[2];
	assign gack_s  = lvl[1];
	assign dak_s   = lvl[0];

	// ==========================================================
	// Slave: ready and no-wait set on backplane rising edges; ready also released by the timeout on any ref_clk edge
	logic [WW-1:0] wait_q;
	logic [RW-1:0] rdy_tmr_q;
	logic          ready_oe_q;
	logic          nowait_q;
	logic          busy_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wait_q       <= backplane_pkg::WAIT_CNT_RST;
			rdy_tmr_q    <= '0;
			ready_oe_q   <= 1'b0;
			nowait_q     <= 1'b0;
			busy_q       <= 1'b0;
			slave_access <= 1'b0;
			slave_mem    <= 1'b0;
		end else begin
			slave_access <= 1'b0;
			rdy_tmr_q    <= ready_oe_q ? rdy_tmr_q + RW'(1) : '0;
			if (ready_oe_q && rdy_tmr_q >= RW'(READY_MAX - 1)) begin
				ready_oe_q <= 1'b0;
			end
			if (rs[6] && busy_q) begin
				busy_q       <= 1'b0;
				nowait_q     <= 1'b0;
				ready_oe_q   <= 1'b0;
				slave_access <= 1'b1;
			end else if (bp_rise) begin
				if (!start_s && !busy_q && !bm_busy) begin
					busy_q     <= 1'b1;
					slave_mem  <= bp.mem_io_sel;
					wait_q     <= slave_wait;
					ready_oe_q <= slave_wait != '0;
					nowait_q   <= slave_fast && slave_wait == '0;
				end else if (ready_oe_q) begin
					if (wait_q <= WW'(1)) begin
						ready_oe_q <= 1'b0;
					end
					wait_q <= wait_q - WW'(1);
				end
			end
		end
	end
	assign bp.far_ready_oe  = ready_oe_q;
	assign bp.far_nowait_oe = nowait_q;

	// ==========================================================
	// DMA slave, qualified by this slot's DMA grant
	logic tc_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dma_xfer  <= 1'b0;
			dma_to_io <= 1'b0;
			dma_done  <= 1'b0;
			tc_q      <= 1'b0;
		end else begin
			dma_xfer  <= !dak_s && (fl[4] || fl[3]);
			dma_to_io <= fl[4] ? 1'b1 : (fl[3] ? 1'b0 : dma_to_io);
			dma_done  <= !dak_s && rs[2] && !tc_q;
			tc_q      <= !dak_s && dma_stop;
		end
	end
	assign bp.far_tc_o  = tc_q;
	assign bp.far_tc_oe = tc_q;

	// ==========================================================
	// Borrowing master
	backplane_pkg::far_master_state_type fm_q;
	logic claim_n_q;
	logic mstart_q;
	logic mio_q;
	logic lock_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			fm_q      <= backplane_pkg::FM_IDLE;
			claim_n_q <= 1'b1;
			mstart_q  <= 1'b1;
			mio_q     <= 1'b1;
			lock_q    <= 1'b0;
			bm_busy   <= 1'b0;
			bm_done   <= 1'b0;
		end else begin
			bm_done <= 1'b0;
			unique case (fm_q)
				backplane_pkg::FM_IDLE: begin
					if (bp_fall && bm_req) begin
						claim_n_q <= 1'b0;
						fm_q      <= backplane_pkg::FM_CLAIM;
					end
				end
				backplane_pkg::FM_CLAIM: begin
					if (!gack_s) begin
						bm_busy <= 1'b1;
						mio_q   <= bm_mem;
						lock_q  <= bm_lock;
						fm_q    <= backplane_pkg::FM_ADDR;
					end
				end
				backplane_pkg::FM_ADDR: begin
					if (bp_rise) begin
						mstart_q <= 1'b0;
						fm_q     <= backplane_pkg::FM_START;
					end
				end
				backplane_pkg::FM_START: begin
					if (bp_rise) begin
						mstart_q <= 1'b1;
						fm_q     <= backplane_pkg::FM_WAIT;
					end
				end
				backplane_pkg::FM_WAIT: begin
					if (rs[6]) begin
						bm_done <= 1'b1;
						lock_q  <= 1'b0;
						fm_q    <= backplane_pkg::FM_DONE;
					end
				end
				backplane_pkg::FM_DONE: begin
					if (bp_fall) begin
						claim_n_q <= 1'b1;
						bm_busy   <= 1'b0;
						fm_q      <= backplane_pkg::FM_IDLE;
					end
				end
				default: fm_q <= backplane_pkg::FM_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Per-slot line drivers
	logic irq_q;
	logic dreq_q;
	logic shared_bus_request_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq_q   <= 1'b0;
			dreq_q  <= 1'b0;
			shared_bus_request_q <= 1'b0;
		end else begin
			irq_q   <= irq_in;
			dreq_q  <= dma_req;
			shared_bus_request_q <= shared_req;
		end
	end

	always_comb begin
		bp.master_claim_n           = '1;
		bp.master_claim_n[SLOT]     = claim_n_q;
		bp.dma_slot_request_n       = '1;
		bp.dma_slot_request_n[SLOT] = !dreq_q;
		bp.slot_interrupt_line      = '0;
		bp.slot_interrupt_line[SLOT] = irq_q;
	end
	assign bp.shared_bus_request_n = !shared_bus_request_q;
	assign bp.far_start_o  = mstart_q;
	assign bp.far_start_oe = bm_busy;
	assign bp.far_mio_o    = mio_q;
	assign bp.far_mio_oe   = bm_busy;
	assign bp.far_lock_oe  = lock_q;
endmodule

// ### backplane_cycle_arbitration_dma_control_sva.sv
`timescale 1ns/100ps
module backplane_cycle_arbitration_dma_control_sva #(
	parameter int N = backplane_pkg::N_SLOTS
) (
	input wire logic         ref_clk,
	input wire logic         rst_n,
	input wire logic         bp_clk,
	input wire logic         command_n,
	input wire logic         cycle_start_n,
	input wire logic         slave_ready_signal,
	input wire logic         dma_mem_to_io_strobe_n,
	input wire logic         dma_io_to_mem_strobe_n,
	input wire logic [N-1:0] master_claim_n,
	input wire logic [N-1:0] grant_acknowledge_n,
	input wire logic [N-1:0] dma_grant_acknowledge_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Command timing
	sequence cmd_on;
		$fell(command_n);
	endsequence
	sequence cmd_floor;
		!command_n [*8];
	endsequence
	AST_CMD_START: assert property (cmd_on |-> cycle_start_n) else $error("cmd early");
	AST_CMD_SYNC: assert property ($changed(command_n) |-> bp_clk) else $error("cmd off");
	AST_CMD_MIN: assert property (cmd_on |-> cmd_floor) else $error("cmd short");
	AST_CMD_WAIT: assert property (!command_n && !slave_ready_signal |=> !command_n)
		else $error("cmd ended while not ready");
	// ==========================================================
	// Arbitration and DMA
	AST_GNT_ONE: assert property ($onehot0(~grant_acknowledge_n)) else $error("two grants");
	AST_GNT_EDGE: assert property ($changed(grant_acknowledge_n) |-> bp_clk) else $error("gnt");
	AST_GNT_HOLD: assert property (|(~grant_acknowledge_n & ~master_claim_n)
		|=> $stable(grant_acknowledge_n)) else $error("grant dropped");
	AST_DAK_ONE: assert property ($onehot0(~dma_grant_acknowledge_n)) else $error("two dak");
	AST_M2IO: assert property (!dma_mem_to_io_strobe_n |-> !(&dma_grant_acknowledge_n))
		else $error("strobe without dak");
	AST_IO2M: assert property (!dma_io_to_mem_strobe_n |-> !(&dma_grant_acknowledge_n))
		else $error("strobe without dak");
	AST_NO_DMA: assert property ((!slave_ready_signal [*4] ##0 &dma_grant_acknowledge_n)
		|=> &dma_grant_acknowledge_n) else $error("dma while not ready");
endmodule

// ### tb_backplane_cycle_arbitration_dma_control.sv
`timescale 1ns/100ps
module tb_backplane_cycle_arbitration_dma_control;
	localparam int N = backplane_pkg::N_SLOTS;
	logic       ref_clk = 0, rst_n = 0, req_valid = 0, req_mem = 0, req_lock = 0;
	logic       dma_m2io = 0, slave_fast = 0, irq_in = 0, dma_req = 0, bm_req = 0, bm_mem = 0;
	logic [7:0] dma_len = 8'h01, beats = 8'h00, v;
	logic [3:0] slave_wait = 4'h0, owner_slot;
	logic [N-1:0] irq_pending, irq_mode = '1;
	logic       req_ready, req_done, req_early, dma_active, dma_beat, borrowed, dma_xfer;
	logic       dma_to_io, bm_done, prev_b = 0, prev_a = 0, bm_lock = 0, dma_stop = 0;
	logic [7:0] q[$];
	int         err_total = 0, comparisons = 0, cyc = 0, seed = 54;
	backplane_if bus ();
	central_end #(.N(N)) central_end_i (.ref_clk(ref_clk), .rst_n(rst_n), .bp(bus),
		.req_valid(req_valid), .req_mem(req_mem), .req_lock(req_lock), .req_ready(req_ready),
		.req_done(req_done), .req_early(req_early), .irq_edge_mode(irq_mode),
		.irq_pending(irq_pending), .dma_mem_to_io(dma_m2io), .dma_len(dma_len),
		.dma_active(dma_active), .dma_beat(dma_beat), .dma_slot(), .borrowed(borrowed),
		.owner_slot(owner_slot), .shared_granted());
	board_end #(.N(N), .SLOT(1), .READY_MAX(50)) board_end_i (.ref_clk(ref_clk),
		.rst_n(rst_n), .bp(bus), .slave_wait(slave_wait), .slave_fast(slave_fast),
		.slave_access(), .slave_mem(), .irq_in(irq_in), .shared_req(1'b0), .dma_req(dma_req),
		.dma_stop(dma_stop), .dma_xfer(dma_xfer), .dma_to_io(dma_to_io), .dma_done(),
		.bm_req(bm_req), .bm_mem(bm_mem), .bm_lock(bm_lock), .bm_busy(), .bm_done(bm_done));
	backplane_cycle_arbitration_dma_control_sva #(.N(N)) chk_i (.ref_clk(ref_clk),
		.rst_n(rst_n), .bp_clk(bus.bp_clk), .command_n(bus.command_n),
		.cycle_start_n(bus.cycle_start_n), .slave_ready_signal(bus.slave_ready_signal),
		.dma_mem_to_io_strobe_n(bus.dma_mem_to_io_strobe_n),
		.dma_io_to_mem_strobe_n(bus.dma_io_to_mem_strobe_n),
		.master_claim_n(bus.master_claim_n), .grant_acknowledge_n(bus.grant_acknowledge_n),
		.dma_grant_acknowledge_n(bus.dma_grant_acknowledge_n));
	always #2.5 ref_clk = ~ref_clk;
	// ==========================================================
	// Reporting
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_of_test();
		end
	end
	// ==========================================================
	// Result watcher
	always @(posedge ref_clk) begin
		prev_b <= borrowed;
		prev_a <= dma_active;
		beats <= beats + {7'h0, dma_beat};
		if (req_done === 1'b1) check("early", {7'h0, req_early}, q.pop_front());
		if (borrowed === 1'b1 && prev_b === 1'b0) check("owner", {4'h0, owner_slot}, q.pop_front());
		if (dma_xfer === 1'b1) check("dir", {7'h0, dma_to_io}, {7'h0, dma_m2io});
		if ((|irq_pending) === 1'b1) check("irq", irq_pending[7:0], q.pop_front());
		if (dma_active === 1'b0 && prev_a === 1'b1) begin
			check("beats", beats + {7'h0, dma_beat}, q.pop_front());
			beats <= 8'h00;
		end
	end
	// ==========================================================
	// Stimulus
	initial begin
		repeat (10) @(posedge ref_clk);
		#1 rst_n = 1;
		for (int i = 0; i < 6; i++) begin
			@(posedge ref_clk iff req_ready === 1'b1);
			#1 v = $random(seed);
			slave_wait = (i == 0) ? 4'h0 : {2'h0, v[1:0]};
			slave_fast = (i == 0) | v[2];
			req_mem = v[3];
			req_lock = v[4];
			q.push_back({7'h0, slave_fast && slave_wait == 4'h0});
			req_valid = 1;
			do @(posedge ref_clk); while (req_ready !== 1'b1);
			#1 req_valid = 0;
		end
		q.push_back(8'h01);
		@(posedge ref_clk iff req_ready === 1'b1);
		#1 bm_mem = v[5];
		bm_lock = v[6];
		bm_req = 1;
		@(posedge ref_clk iff bm_done === 1'b1);
		#1 bm_req = 0;
		@(posedge ref_clk iff borrowed === 1'b0);
		for (int d = 0; d < 2; d++) begin
			#1 v = $random(seed);
			dma_m2io = d[0];
			dma_len = {5'h0, v[2:0]} + 8'h02;
			q.push_back(d[0] ? 8'h01 : dma_len);
			dma_req = 1;
			@(posedge ref_clk iff dma_xfer === 1'b1);
			#1 dma_stop = d[0];
			@(posedge ref_clk iff prev_a === 1'b1 && dma_active === 1'b0);
			#1 dma_req = 0;
			dma_stop = 0;
			repeat (20) @(posedge ref_clk);
		end
		#1 q.push_back(8'h02);
		irq_in = 1;
		repeat (20) @(posedge ref_clk);
		#1 irq_mode[1] = 1'b0;
		irq_in = 0;
		repeat (4) q.push_back(8'h02);
		repeat (4) @(posedge ref_clk);
		#1 irq_in = 1;
		repeat (20) @(posedge ref_clk);
		end_of_test();
	end
endmodule
